/* File: hw/gpao_params.svh */
// Purpose: Constants for the alarm output block.
// Assumes: 250 MHz system clock.
// Notes:   Offsets are byte addresses on the plain register port.
`ifndef GPAO_PARAMS_SVH
`define GPAO_PARAMS_SVH

`define GPAO_NUM_OUT       3
`define GPAO_NUM_EV        10
`define GPAO_NUM_DLY       5
`define GPAO_NUM_PORT      2

// Event bit positions; the delayable events sit at the bottom
`define GPAO_EV_HW_FAULT   0
`define GPAO_EV_LOCK_ERR   1
`define GPAO_EV_LOCK_WARN  2
`define GPAO_EV_TIME_ERR   3
`define GPAO_EV_TIME_WARN  4
`define GPAO_EV_SUPPLY     5
`define GPAO_EV_SECONDARY  6
`define GPAO_EV_ALARM_TIME 7
`define GPAO_EV_LOSS1      8
`define GPAO_EV_LOSS2      9

`define GPAO_ADDR_W        8
`define GPAO_DATA_W        32
`define GPAO_DLY_W         16
`define GPAO_MSC_W         18
`define GPAO_PCNT_W        28
`define GPAO_TIME_W        24

`define GPAO_OFF_SEL0      8'h00
`define GPAO_OFF_ALARM     8'h0C
`define GPAO_OFF_DLY0      8'h10
`define GPAO_OFF_STATUS    8'h24
`define GPAO_OFF_MASK      8'h28
`define GPAO_OFF_LIVE      8'h2C
`define GPAO_OFF_STRIDE    8'h04
`define GPAO_LIVE_OUT_LSB  16

`define GPAO_SEL_RST       10'h000
`define GPAO_EV_RST        10'h000
`define GPAO_ALARM_RST     24'h000000
`define GPAO_DLY_RST       16'h0000
`define GPAO_OUT_IDLE      3'h7
`define GPAO_RD_RST        32'h00000000

// Timing
`define GPAO_CLK_MHZ       250
`define GPAO_US_PER_MS     1000
`define GPAO_MS_PER_S      1000
`define GPAO_ALARM_PULSE_S 1
`define GPAO_LOSS_PULSE_MS 20

`endif

/* File: hw/gpao_pkg.sv */
// Purpose: Types shared by the alarm output block.
// Assumes: Constants from the params header.
// Notes:   Indicator colours are two-bit codes.
`include "gpao_params.svh"
package gpao_pkg;

  typedef enum logic [1:0] {
    GPAO_OFF    = 2'h0,
    GPAO_GREEN  = 2'h1,
    GPAO_YELLOW = 2'h2,
    GPAO_RED    = 2'h3
  } gpao_color_type;

  typedef struct packed {
    gpao_color_type first_supply_indicator;
    gpao_color_type second_supply_indicator;
    gpao_color_type reference;
    gpao_color_type time_of_day;
  } gpao_ind_type;

  typedef struct packed {
    logic [7:0] hh;
    logic [7:0] mm;
    logic [7:0] ss;
  } gpao_hms_type;

  typedef logic [`GPAO_NUM_EV-1:0] gpao_ev_type;

  typedef enum logic [1:0] {
    GPAO_P_IDLE = 2'h1,
    GPAO_P_BUSY = 2'h2
  } gpao_pst_type;

endpackage

/* File: hw/gpao_pulse.sv */
// Purpose: Fixed-length pulse timer started by a one-cycle fire strobe.
// Assumes: fire_i is a single-cycle strobe.
// Notes:   A fire during a pulse restarts the full length.
`timescale 1ns/1ns
`default_nettype none
`include "gpao_params.svh"
module gpao_pulse #(
  parameter int unsigned LEN_CYC = 1
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // Trigger and pulse
  input  wire logic fire_i,
  output logic      pulse_o
);

  gpao_pkg::gpao_pst_type    state_r;
  logic [`GPAO_PCNT_W-1:0]   cnt_r;
  logic                      last_w;

  assign last_w  = (cnt_r == `GPAO_PCNT_W'(LEN_CYC - 1));
  assign pulse_o = (state_r == gpao_pkg::GPAO_P_BUSY);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= gpao_pkg::GPAO_P_IDLE;
    end else if (ce_i) begin
      case (state_r)
        gpao_pkg::GPAO_P_IDLE: begin
          if (fire_i) begin
            state_r <= gpao_pkg::GPAO_P_BUSY;
          end
        end
        gpao_pkg::GPAO_P_BUSY: begin
          if (last_w && !fire_i) begin
            state_r <= gpao_pkg::GPAO_P_IDLE;
          end
        end
        default: state_r <= gpao_pkg::GPAO_P_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (fire_i || state_r != gpao_pkg::GPAO_P_BUSY) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + `GPAO_PCNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/gpao_delay.sv */
// Purpose: Persistence filter: passes a level once it has held for N ms.
// Assumes: delay_i is stable while the level is present.
// Notes:   A zero delay passes the level straight through.
`timescale 1ns/1ns
`default_nettype none
`include "gpao_params.svh"
module gpao_delay #(
  parameter int unsigned MS_CYC = 1
) (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  // Level and setting
  input  wire logic                   level_i,
  input  wire logic [`GPAO_DLY_W-1:0] delay_i,
  output logic                        hit_o
);

  logic [`GPAO_MSC_W-1:0] sub_r;
  logic [`GPAO_DLY_W-1:0] ms_r;
  logic                   wrap_w;
  logic                   full_w;

  assign wrap_w = (sub_r == `GPAO_MSC_W'(MS_CYC - 1));
  assign full_w = (ms_r == '1);
  assign hit_o  = level_i && (ms_r >= delay_i);

  // Cycle prescaler restarts with each new occurrence
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sub_r <= '0;
    end else if (ce_i) begin
      if (!level_i || wrap_w) begin
        sub_r <= '0;
      end else begin
        sub_r <= sub_r + `GPAO_MSC_W'(1);
      end
    end
  end

  // Whole milliseconds of continuous presence, saturating
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ms_r <= '0;
    end else if (ce_i) begin
      if (!level_i) begin
        ms_r <= '0;
      end else if (wrap_w && !full_w) begin
        ms_r <= ms_r + `GPAO_DLY_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/gpao_top.sv */
// Purpose: Three active-low alarm outputs driven by selected status events.
// Assumes: Status inputs synchronous to ref_clk_i; plain register port.
// Notes:   ce_i low freezes every register, register writes included.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "gpao_params.svh"

// Functional notes
// [R01] Three outputs each assert on the OR of the events selected for it.
// [R02] Outputs are active low and follow level events while they last.
// [R03] The alarm-time event gives each selecting output one 1 s pulse.
// [R04] Each leader-loss event gives each selecting output one 20 ms pulse.
// [R05] Hardware fault is active while the fault indicator is lit.
// [R06] Supply fault is active while either supply indicator is red.
// [R07] Lock error follows a red, lock warning a yellow reference indicator.
// [R08] Time error follows a red, time warning a yellow time indicator.
// [R09] Secondary active is a level while the secondary reference is used.
// [R10] Alarm time fires when HH:MM:SS of the program time equals the set time.
// [R11] Leader loss fires per port on a change from active leader to passive.
// [R12] A delayed alarm asserts only after holding for its whole delay.
// [R13] Only fault, lock error/warning and time error/warning take delays.
// [R14] Reset idles outputs high, clears timers and primes edge detectors.
module gpao_top #(
  parameter int unsigned MS_CYC =
    `GPAO_CLK_MHZ * `GPAO_US_PER_MS,
  parameter int unsigned ALARM_PULSE_CYC =
    `GPAO_ALARM_PULSE_S * `GPAO_MS_PER_S * `GPAO_US_PER_MS * `GPAO_CLK_MHZ,
  parameter int unsigned LOSS_PULSE_CYC =
    `GPAO_LOSS_PULSE_MS * `GPAO_US_PER_MS * `GPAO_CLK_MHZ
) (
  // Clock, reset and enable
  input  wire logic                     ref_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     ce_i,
  // Register port
  input  wire logic [`GPAO_ADDR_W-1:0]  addr_i,
  input  wire logic [`GPAO_DATA_W-1:0]  wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [`GPAO_DATA_W-1:0]  rdata_o,
  // Instrument status
  input  wire logic                     fault_lit_i,
  input  wire gpao_pkg::gpao_ind_type   indicators_i,
  input  wire logic                     secondary_active_i,
  input  wire gpao_pkg::gpao_hms_type   prog_time_i,
  input  wire logic [`GPAO_NUM_PORT-1:0] timing_leader_i,
  // Alarm pins and interrupt
  output logic      [`GPAO_NUM_OUT-1:0] alarm_n_o,
  output logic                          irq_o
);

  function automatic logic gpao_is(input gpao_pkg::gpao_color_type c,
                                   input gpao_pkg::gpao_color_type want);
    gpao_is = (c == want);
  endfunction

  function automatic logic gpao_hit(input logic [`GPAO_ADDR_W-1:0] a,
                                    input logic [`GPAO_ADDR_W-1:0] off);
    gpao_hit = (a == off);
  endfunction

  // Configuration and status registers
  gpao_pkg::gpao_ev_type     sel_r [`GPAO_NUM_OUT];
  logic [`GPAO_DLY_W-1:0]    dly_r [`GPAO_NUM_DLY];
  gpao_pkg::gpao_hms_type    alarm_time_r;
  gpao_pkg::gpao_ev_type     status_r;
  gpao_pkg::gpao_ev_type     mask_r;
  logic [`GPAO_DATA_W-1:0]   rdata_r;
  logic                      irq_r;

  // Event path
  gpao_pkg::gpao_ev_type     raw_w;
  gpao_pkg::gpao_ev_type     eff_w;
  gpao_pkg::gpao_ev_type     eff_r;
  logic [`GPAO_NUM_DLY-1:0]  dly_hit_w;
  logic [`GPAO_NUM_OUT-1:0]  alarm_n_r;

  // Edge detection
  logic                      primed_r;
  logic                      match_w;
  logic                      match_prev_r;
  logic [`GPAO_NUM_PORT-1:0] leader_prev_r;
  logic                      alarm_fire_w;
  logic [`GPAO_NUM_PORT-1:0] loss_fire_w;
  logic                      alarm_pulse_w;
  logic [`GPAO_NUM_PORT-1:0] loss_pulse_w;

  gpao_pkg::gpao_ev_type     clr_w;
  logic [`GPAO_DATA_W-1:0]   rd_mux_w;

  // Raw levels from the indicator states and the other instrument status inputs
  always_comb begin
    raw_w = `GPAO_EV_RST;
    raw_w[`GPAO_EV_HW_FAULT]  = fault_lit_i; // [R05]
    raw_w[`GPAO_EV_SUPPLY]    =
      gpao_is(indicators_i.first_supply_indicator, gpao_pkg::GPAO_RED) ||
      gpao_is(indicators_i.second_supply_indicator, gpao_pkg::GPAO_RED);
      // [R06]
    raw_w[`GPAO_EV_LOCK_ERR]  =
      gpao_is(indicators_i.reference, gpao_pkg::GPAO_RED); // [R07]
    raw_w[`GPAO_EV_LOCK_WARN] =
      gpao_is(indicators_i.reference, gpao_pkg::GPAO_YELLOW); // [R07]
    raw_w[`GPAO_EV_TIME_ERR]  =
      gpao_is(indicators_i.time_of_day, gpao_pkg::GPAO_RED); // [R08]
    raw_w[`GPAO_EV_TIME_WARN] =
      gpao_is(indicators_i.time_of_day, gpao_pkg::GPAO_YELLOW); // [R08]
    raw_w[`GPAO_EV_SECONDARY] = secondary_active_i; // [R09]
    raw_w[`GPAO_EV_ALARM_TIME] = match_w;
    raw_w[`GPAO_EV_LOSS1]     = !timing_leader_i[0];
    raw_w[`GPAO_EV_LOSS2]     = !timing_leader_i[1];
  end

  assign match_w = (prog_time_i == alarm_time_r); // [R10]
  assign alarm_fire_w = primed_r && match_w && !match_prev_r; // [R10]

  // Detectors take the live levels on the first enabled cycle, no firing
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      primed_r      <= 1'b0;
      match_prev_r  <= 1'b0;
      leader_prev_r <= '0;
    end else if (ce_i) begin
      primed_r      <= 1'b1; // [R14]
      match_prev_r  <= match_w; // [R14]
      leader_prev_r <= timing_leader_i; // [R14]
    end
  end

  gpao_pulse #(
    .LEN_CYC (ALARM_PULSE_CYC)
  ) u_alarm_pulse (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .fire_i    (alarm_fire_w),
    .pulse_o   (alarm_pulse_w)
  ); // [R03]

  genvar p;
  generate
    for (p = 0; p < `GPAO_NUM_PORT; p = p + 1) begin : g_port
      assign loss_fire_w[p] =
        primed_r && leader_prev_r[p] && !timing_leader_i[p]; // [R11]
      gpao_pulse #(
        .LEN_CYC (LOSS_PULSE_CYC)
      ) u_loss_pulse (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .fire_i    (loss_fire_w[p]),
        .pulse_o   (loss_pulse_w[p])
      ); // [R04]
    end
  endgenerate

  // Persistence filters on the delayable events only
  genvar d;
  generate
    for (d = 0; d < `GPAO_NUM_DLY; d = d + 1) begin : g_dly
      gpao_delay #(
        .MS_CYC (MS_CYC)
      ) u_delay (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .level_i   (raw_w[d]),
        .delay_i   (dly_r[d]),
        .hit_o     (dly_hit_w[d])
      ); // [R12]

      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          dly_r[d] <= `GPAO_DLY_RST;
        end else if (ce_i && wr_i && gpao_hit(addr_i,
            `GPAO_ADDR_W'(`GPAO_OFF_DLY0 + `GPAO_OFF_STRIDE * d))) begin
          dly_r[d] <= wdata_i[`GPAO_DLY_W-1:0];
        end
      end
    end
  endgenerate

  // Effective events: filtered, direct, or stretched into pulses
  always_comb begin
    eff_w = raw_w; // [R13]
    eff_w[`GPAO_NUM_DLY-1:0]   = dly_hit_w; // [R13]
    eff_w[`GPAO_EV_ALARM_TIME] = alarm_pulse_w; // [R03]
    eff_w[`GPAO_EV_LOSS1]      = loss_pulse_w[0]; // [R04]
    eff_w[`GPAO_EV_LOSS2]      = loss_pulse_w[1]; // [R04]
  end

  genvar k;
  generate
    for (k = 0; k < `GPAO_NUM_OUT; k = k + 1) begin : g_out
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          sel_r[k] <= `GPAO_SEL_RST;
        end else if (ce_i && wr_i && gpao_hit(addr_i,
            `GPAO_ADDR_W'(`GPAO_OFF_SEL0 + `GPAO_OFF_STRIDE * k))) begin
          sel_r[k] <= wdata_i[`GPAO_NUM_EV-1:0];
        end
      end

      // Pin low while any selected event is active
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          alarm_n_r[k] <= 1'b1; // [R14]
        end else if (ce_i) begin
          alarm_n_r[k] <= ~(|(sel_r[k] & eff_w)); // [R01] [R02]
        end
      end
    end
  endgenerate

  assign alarm_n_o = alarm_n_r;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_time_r <= `GPAO_ALARM_RST;
    end else if (ce_i && wr_i && gpao_hit(addr_i, `GPAO_OFF_ALARM)) begin
      alarm_time_r <= wdata_i[`GPAO_TIME_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mask_r <= `GPAO_EV_RST;
    end else if (ce_i && wr_i && gpao_hit(addr_i, `GPAO_OFF_MASK)) begin
      mask_r <= wdata_i[`GPAO_NUM_EV-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      eff_r <= `GPAO_EV_RST;
    end else if (ce_i) begin
      eff_r <= eff_w;
    end
  end

  // Sticky status: a new onset beats a simultaneous write-one clear
  assign clr_w = (wr_i && gpao_hit(addr_i, `GPAO_OFF_STATUS)) ?
                 wdata_i[`GPAO_NUM_EV-1:0] : `GPAO_EV_RST;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= `GPAO_EV_RST;
    end else if (ce_i) begin
      status_r <= (status_r & ~clr_w) | (eff_w & ~eff_r);
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else if (ce_i) begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign irq_o = irq_r;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux_w = `GPAO_RD_RST;
    for (int i = 0; i < `GPAO_NUM_OUT; i++) begin
      if (gpao_hit(addr_i,
          `GPAO_ADDR_W'(`GPAO_OFF_SEL0 + `GPAO_OFF_STRIDE * i))) begin
        rd_mux_w[`GPAO_NUM_EV-1:0] = sel_r[i];
      end
    end
    for (int i = 0; i < `GPAO_NUM_DLY; i++) begin
      if (gpao_hit(addr_i,
          `GPAO_ADDR_W'(`GPAO_OFF_DLY0 + `GPAO_OFF_STRIDE * i))) begin
        rd_mux_w[`GPAO_DLY_W-1:0] = dly_r[i];
      end
    end
    if (gpao_hit(addr_i, `GPAO_OFF_ALARM)) begin
      rd_mux_w[`GPAO_TIME_W-1:0] = alarm_time_r;
    end
    if (gpao_hit(addr_i, `GPAO_OFF_STATUS)) begin
      rd_mux_w[`GPAO_NUM_EV-1:0] = status_r;
    end
    if (gpao_hit(addr_i, `GPAO_OFF_MASK)) begin
      rd_mux_w[`GPAO_NUM_EV-1:0] = mask_r;
    end
    if (gpao_hit(addr_i, `GPAO_OFF_LIVE)) begin
      rd_mux_w[`GPAO_NUM_EV-1:0] = eff_r;
      rd_mux_w[`GPAO_LIVE_OUT_LSB +: `GPAO_NUM_OUT] = ~alarm_n_r;
    end
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= `GPAO_RD_RST;
    end else if (ce_i) begin
      rdata_r <= rd_i ? rd_mux_w : `GPAO_RD_RST;
    end
  end

  assign rdata_o = rdata_r;

endmodule
`default_nettype wire

/* File: tb/gpao_top_props.sv */
// Purpose: Port-level checks for the alarm output block.
// Assumes: ce_i goes low only while the pins are steady.
// Notes:   Select, alarm time and delay 0 are shadowed from bus writes.
`timescale 1ns/1ns
`default_nettype none
`include "gpao_params.svh"
module gpao_top_chk #(
  parameter int unsigned MS_CYC          = 1,
  parameter int unsigned ALARM_PULSE_CYC = 1,
  parameter int unsigned LOSS_PULSE_CYC  = 1
) (
  // Clock, reset and enable
  input wire logic                       ref_clk_i,
  input wire logic                       reset_i,
  input wire logic                       ce_i,
  // Register port
  input wire logic [`GPAO_ADDR_W-1:0]    addr_i,
  input wire logic [`GPAO_DATA_W-1:0]    wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [`GPAO_DATA_W-1:0]    rdata_o,
  // Instrument status
  input wire logic                       fault_lit_i,
  input wire gpao_pkg::gpao_ind_type     indicators_i,
  input wire logic                       secondary_active_i,
  input wire gpao_pkg::gpao_hms_type     prog_time_i,
  input wire logic [`GPAO_NUM_PORT-1:0]  timing_leader_i,
  // Alarm pins and interrupt
  input wire logic [`GPAO_NUM_OUT-1:0]   alarm_n_o,
  input wire logic                       irq_o
);
  logic [9:0]  sel_r [3];
  logic [23:0] at_r;
  logic [15:0] d0_r;
  int unsigned lo_r [3];
  int unsigned held_r;
  logic        red1;
  logic        hit;
  assign red1 = indicators_i[7:6] == 2'h3 || indicators_i[5:4] == 2'h3;
  assign hit  = prog_time_i == at_r;
  // Configuration as written over the register port
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_r <= '{default: 10'h000};
      at_r  <= 24'h000000;
      d0_r  <= 16'h0000;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        8'h00: sel_r[0] <= wdata_i[9:0];
        8'h04: sel_r[1] <= wdata_i[9:0];
        8'h08: sel_r[2] <= wdata_i[9:0];
        8'h0C: at_r <= wdata_i[23:0];
        8'h10: d0_r <= wdata_i[15:0];
        default: ;
      endcase
    end
  end
  // Low-run length per pin and fault hold time
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lo_r   <= '{default: 0};
      held_r <= 0;
    end else begin
      for (int k = 0; k < 3; k++)
        lo_r[k] <= alarm_n_o[k] ? 0 : lo_r[k] + 1;
      held_r <= fault_lit_i ? held_r + 1 : 0;
    end
  end
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  property p_rst_idle;
    $fell(reset_i) |-> alarm_n_o == 3'h7 && !irq_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not idle after reset");
  property p_supply;
    sel_r[0][5] && red1 |=> !alarm_n_o[0];
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply fault did not assert output 1");
  property p_release;
    (sel_r[2] & ~10'h060) == 10'h000 && !red1 && !secondary_active_i
      |=> alarm_n_o[2];
  endproperty
  a_release: assert property (p_release)
    else $error("output 3 held without a condition");
  property p_fault;
    sel_r[0][0] && d0_r == 16'h0000 && fault_lit_i |=> !alarm_n_o[0];
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault did not assert output 1");
  property p_delay;
    $fell(alarm_n_o[0]) && sel_r[0] == 10'h001 |-> held_r >= d0_r * MS_CYC;
  endproperty
  a_delay: assert property (p_delay)
    else $error("delayed fault asserted early");
  property p_time_fire;
    $rose(hit) && sel_r[0] == 10'h080 |-> ##2 !alarm_n_o[0];
  endproperty
  a_time_fire: assert property (p_time_fire)
    else $error("alarm time match gave no pulse");
  property p_time_len;
    $rose(alarm_n_o[0]) && sel_r[0] == 10'h080 |-> lo_r[0] == ALARM_PULSE_CYC;
  endproperty
  a_time_len: assert property (p_time_len)
    else $error("alarm time pulse has wrong length");
  property p_loss_fire;
    $fell(timing_leader_i[0]) && sel_r[1] == 10'h100 |-> ##2 !alarm_n_o[1];
  endproperty
  a_loss_fire: assert property (p_loss_fire)
    else $error("leader loss gave no pulse");
  property p_loss_len;
    $rose(alarm_n_o[1]) && sel_r[1] == 10'h100 |-> lo_r[1] == LOSS_PULSE_CYC;
  endproperty
  a_loss_len: assert property (p_loss_len)
    else $error("leader loss pulse has wrong length");
  c_time: cover property ($rose(alarm_n_o[0]) && sel_r[0] == 10'h080);
  c_loss: cover property ($rose(alarm_n_o[1]) && sel_r[1] == 10'h100);
  c_irq: cover property ($rose(irq_o));
endmodule
bind gpao_top gpao_top_chk #(
  .MS_CYC(MS_CYC),
  .ALARM_PULSE_CYC(ALARM_PULSE_CYC),
  .LOSS_PULSE_CYC(LOSS_PULSE_CYC)
) i_gpao_top_chk (.ref_clk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .fault_lit_i, .indicators_i, .secondary_active_i,
  .prog_time_i, .timing_leader_i, .alarm_n_o, .irq_o);
`default_nettype wire

/* File: tb/gpao_unit.sv */
// Purpose: Alarm monitoring unit watching the three alarm pins.
// Assumes: Pins are active low.
// Notes:   Counts assertions and records the last low width per pin.
`timescale 1ns/1ns
`default_nettype none
module gpao_unit (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // Watched pins and results
  input  wire logic [2:0] alarm_n_i,
  output int unsigned     falls_o [3],
  output int unsigned     width_o [3]
);
  int unsigned run [3];
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      run     <= '{default: 0};
      falls_o <= '{default: 0};
      width_o <= '{default: 0};
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (!alarm_n_i[k]) begin
          run[k] <= run[k] + 1;
          if (run[k] == 0)
            falls_o[k] <= falls_o[k] + 1;
        end else if (run[k] != 0) begin
          width_o[k] <= run[k];
          run[k]     <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the alarm output block.
// Assumes: Short timing parameters; ce_i held high except during the interrupt test.
// Notes:   Pulse widths are measured by the alarm unit model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int unsigned MS = 10;
  localparam int unsigned AP = 50;
  localparam int unsigned LP = 20;
  localparam gpao_pkg::gpao_color_type grn = gpao_pkg::GPAO_GREEN;
  localparam gpao_pkg::gpao_color_type yel = gpao_pkg::GPAO_YELLOW;
  localparam gpao_pkg::gpao_color_type red = gpao_pkg::GPAO_RED;
  localparam logic [2:0] lv_exp [4] = '{3'h4, 3'h4, 3'h1, 3'h7};
  logic                   ref_clk_i;
  logic                   reset_i;
  logic                   ce_i;
  logic [7:0]             addr_i;
  logic [31:0]            wdata_i;
  logic                   wr_i;
  logic                   rd_i;
  logic [31:0]            rdata_o;
  logic                   fault_lit_i;
  gpao_pkg::gpao_ind_type indicators_i;
  logic                   secondary_active_i;
  gpao_pkg::gpao_hms_type prog_time_i;
  logic [1:0]             timing_leader_i;
  logic [2:0]             alarm_n_o;
  logic                   irq_o;
  int unsigned            falls [3], width [3];
  int unsigned            f0, f1;
  int                     error_cnt;
  int                     total_checks;
  gpao_top #(.MS_CYC(MS), .ALARM_PULSE_CYC(AP), .LOSS_PULSE_CYC(LP))
    i_gpao_top (.ref_clk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .fault_lit_i, .indicators_i, .secondary_active_i,
      .prog_time_i, .timing_leader_i, .alarm_n_o, .irq_o);
  gpao_unit i_gpao_unit (.ref_clk_i, .reset_i, .alarm_n_i(alarm_n_o),
    .falls_o(falls), .width_o(width));
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk($sformatf("register %h", a), exp, rdata_o);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic regs_zero;
    for (int a = 0; a <= 48; a += 4)
      rd(8'(a), 32'h0);
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    summarize;
  end
  initial begin
    error_cnt = 0;
    total_checks = 0;
    reset_i = 1'b1;
    ce_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fault_lit_i = 1'b0;
    indicators_i = '{grn, grn, grn, grn};
    secondary_active_i = 1'b0;
    prog_time_i = 24'h010203;
    timing_leader_i = 2'b01;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    cyc(2);
    chk("pins", 32'h7, {29'h0, alarm_n_o});
    chk("irq", 32'h0, {31'h0, irq_o});
    regs_zero;
    done("reset");
    for (int k = 1; k <= 5; k++)
      wr(8'(4 * k + 12), 32'h5);
    wr(8'h00, 32'h020);
    wr(8'h04, 32'h060);
    wr(8'h08, 32'h040);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      indicators_i <= '{k == 0 ? red : grn, k == 1 ? red : grn, grn, grn};
      secondary_active_i <= (k == 2);
      cyc(2);
      chk("pins", {29'h0, lv_exp[k]}, {29'h0, alarm_n_o});
    end
    done("levels");
    wr(8'h00, 32'h001);
    f0 = falls[0];
    @(posedge ref_clk_i) fault_lit_i <= 1'b1;
    cyc(30);
    @(posedge ref_clk_i) fault_lit_i <= 1'b0;
    cyc(3);
    chk("short fault", f0, falls[0]);
    @(posedge ref_clk_i) fault_lit_i <= 1'b1;
    cyc(70);
    chk("held fault", 32'h6, {29'h0, alarm_n_o});
    @(posedge ref_clk_i) fault_lit_i <= 1'b0;
    wr(8'h10, 32'h0);
    @(posedge ref_clk_i) fault_lit_i <= 1'b1;
    cyc(2);
    chk("fault", 32'h6, {29'h0, alarm_n_o});
    @(posedge ref_clk_i) fault_lit_i <= 1'b0;
    done("delay");
    for (int k = 1; k <= 4; k++)
      wr(8'(4 * k + 16), 32'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      indicators_i <= '{grn, grn, k == 0 ? red : k == 1 ? yel : grn,
                        k == 2 ? red : k == 3 ? yel : grn};
      cyc(2);
      rd(8'h2C, 32'h1 << (k + 1));
    end
    @(posedge ref_clk_i) indicators_i <= '{grn, grn, grn, grn};
    done("indicators");
    rd(8'h24, 32'h07F);
    chk("irq", 32'h0, {31'h0, irq_o});
    wr(8'h28, 32'h002);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    wr(8'h28, 32'h000);
    @(posedge ref_clk_i) ce_i <= 1'b1;
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(8'h24, 32'h002);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(8'h24, 32'h07D);
    done("interrupt");
    wr(8'h0C, 32'h123456);
    wr(8'h00, 32'h080);
    f0 = falls[0];
    @(posedge ref_clk_i) prog_time_i <= 24'h133456;
    cyc(5);
    chk("near time", f0, falls[0]);
    @(posedge ref_clk_i) prog_time_i <= 24'h123456;
    cyc(2 * AP);
    @(posedge ref_clk_i) prog_time_i <= 24'h123457;
    cyc(5);
    chk("time pulses", f0 + 1, falls[0]);
    chk("time width", AP, width[0]);
    done("alarm time");
    wr(8'h04, 32'h100);
    wr(8'h08, 32'h200);
    f0 = falls[1];
    f1 = falls[2];
    @(posedge ref_clk_i) timing_leader_i <= 2'b11;
    cyc(5);
    chk("leader rise", f1, falls[2]);
    @(posedge ref_clk_i) timing_leader_i <= 2'b10;
    cyc(LP + 10);
    @(posedge ref_clk_i) timing_leader_i <= 2'b00;
    cyc(LP + 10);
    chk("loss pulses 1", f0 + 1, falls[1]);
    chk("loss width 1", LP, width[1]);
    chk("loss pulses 2", f1 + 1, falls[2]);
    chk("loss width 2", LP, width[2]);
    done("leader loss");
    wr(8'h00, 32'h001);
    @(posedge ref_clk_i) fault_lit_i <= 1'b1;
    cyc(3);
    @(posedge ref_clk_i) reset_i <= 1'b1;
    @(posedge ref_clk_i) fault_lit_i <= 1'b0;
    cyc(2);
    chk("pins", 32'h7, {29'h0, alarm_n_o});
    @(posedge ref_clk_i) reset_i <= 1'b0;
    cyc(2);
    regs_zero;
    done("second reset");
    summarize;
  end
endmodule
`default_nettype wire
